// file: rtl/csr_pkg.sv
// Package: constants and types for the call-state status reporting block
package csr_pkg;
    // ------------------------------------------------------------
    // Widths and bit positions
    // ------------------------------------------------------------
    localparam int          CSR_W         = 16;
    localparam int          BIT_ACTIVE    = 0;
    localparam int          BIT_REGISTER  = 1;
    localparam int          BIT_UNUSED    = 2;
    localparam int          BIT_PAGE      = 3;
    localparam int          BIT_ACCESS    = 4;
    localparam int          BIT_CONNECT   = 5;
    localparam int          OPER_CALL_BIT = 9;
    localparam int          SB_OPER_BIT   = 7;
    localparam int          SB_STD_BIT    = 5;
    localparam logic [15:0] CALL_USED     = 16'h003b;
    localparam logic [15:0] MASK_RST      = 16'h0000;
    localparam logic [7:0]  SRE_RST       = 8'h00;

    // Command selectors on the command port: mask and filter writes, event read, clear, completion query, long reset
    localparam logic [2:0] SEL_CALL_MASK  = 3'h0;
    localparam logic [2:0] SEL_CALL_PTR   = 3'h1;
    localparam logic [2:0] SEL_OPER_MASK  = 3'h2;
    localparam logic [2:0] SEL_SRV_MASK   = 3'h3;
    localparam logic [2:0] SEL_READ_EVENT = 3'h4;
    localparam logic [2:0] SEL_CLEAR      = 3'h5;
    localparam logic [2:0] SEL_OPC_QUERY  = 3'h6;
    localparam logic [2:0] SEL_LONG_RESET = 3'h7;

    // Time of a lengthy reset command, in cycles
    localparam int          LONG_RESET_CYC = 16;

    typedef struct packed {
        logic [2:0]  sel;
        logic [15:0] data;
    } csr_cmd_t;

    typedef enum logic [1:0] {
        CSR_IDLE,
        CSR_BUSY,
        CSR_REPLY
    } csr_state_t;
endpackage : csr_pkg

// file: rtl/csr_top.sv
// Call-state status reporting: condition, filter, event, masks, command queue
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module csr_top #(
    parameter int DEPTH     = 8,
    parameter int RESET_CYC = csr_pkg::LONG_RESET_CYC
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ind_connect,
    input  wire logic             ind_access,
    input  wire logic             ind_page,
    input  wire logic             ind_register,
    input  wire logic             ind_active,
    input  wire logic             std_event_sum,
    input  wire logic             cmd_valid,
    input  wire csr_pkg::csr_cmd_t cmd,
    output logic                  cmd_ready,
    output logic [15:0]           read_data,
    output logic                  read_valid,
    output logic                  opc_reply,
    output logic [15:0]           call_state_condition,
    output logic [15:0]           oper_condition,
    output logic [7:0]            status_byte,
    output logic                  service_request
);
    import csr_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // Command queue
    // ------------------------------------------------------------
    csr_cmd_t             q_mem_reg [DEPTH];
    logic [AW:0]          wr_ptr_reg;
    logic [AW:0]          rd_ptr_reg;
    logic [AW:0]          count;
    logic                 q_empty;
    logic                 push;
    logic                 pop;
    csr_cmd_t             head;

    assign count     = wr_ptr_reg - rd_ptr_reg;
    assign q_empty   = (count == '0);
    assign cmd_ready = (count != (AW+1)'(DEPTH));
    assign push      = cmd_valid && cmd_ready;
    assign head      = q_mem_reg[rd_ptr_reg[AW-1:0]];

    // Queue storage and pointers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                q_mem_reg[wr_ptr_reg[AW-1:0]] <= cmd;
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial executor
    // ------------------------------------------------------------
    csr_state_t  state_reg;
    csr_state_t  state_next;
    logic [15:0] busy_cnt_reg;
    logic        exec;

    // Only one command leaves the queue per idle cycle, so order holds
    assign exec = (state_reg == CSR_IDLE) && !q_empty;
    assign pop  = exec;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CSR_IDLE: begin
                if (exec && head.sel == SEL_LONG_RESET) begin
                    state_next = CSR_BUSY;
                end else if (exec && head.sel == SEL_OPC_QUERY) begin
                    state_next = CSR_REPLY;
                end
            end
            CSR_BUSY: begin
                if (busy_cnt_reg == 16'h0001) begin
                    state_next = CSR_IDLE;
                end
            end
            CSR_REPLY: state_next = CSR_IDLE;
            default:   state_next = CSR_IDLE;
        endcase
    end

    // State and reset-command timer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg    <= CSR_IDLE;
            busy_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (state_reg == CSR_IDLE) begin
                busy_cnt_reg <= 16'(RESET_CYC);
            end else if (state_reg == CSR_BUSY) begin
                busy_cnt_reg <= busy_cnt_reg - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Condition, filter, events, masks
    // ------------------------------------------------------------
    logic [15:0] cond_now;
    logic [15:0] cond_prev_reg;
    logic [15:0] ptr_reg;
    logic [15:0] event_reg;
    logic [15:0] call_mask_reg;
    logic [15:0] oper_mask_reg;
    logic [7:0]  srv_mask_reg;
    logic [15:0] rise_set;
    logic        do_cmd;
    logic        ev_read;
    logic        ev_clear;
    logic        call_summary;
    logic        oper_summary;
    logic        reset_cmd;

    // Bit 2 has no indicator and reads as zero
    assign cond_now = {10'h000, ind_connect, ind_access, ind_page,
                       1'b0, ind_register, ind_active};

    assign rise_set = cond_now & ~cond_prev_reg & ptr_reg & CALL_USED;
    assign do_cmd    = exec;
    assign ev_read   = do_cmd && head.sel == SEL_READ_EVENT;
    assign ev_clear  = do_cmd && head.sel == SEL_CLEAR;
    assign reset_cmd = do_cmd && head.sel == SEL_LONG_RESET;

    assign call_summary = |(event_reg & call_mask_reg);
    assign oper_condition = {6'h00, call_summary, 9'h000};
    assign oper_summary = |(oper_condition & oper_mask_reg);
    assign status_byte  = {oper_summary, 1'b0, std_event_sum, 5'h00};
    assign service_request = |(status_byte & srv_mask_reg
                               & 8'ha0);

    // Latched events: a new edge beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cond_prev_reg <= 16'h0000;
            event_reg     <= MASK_RST;
        end else begin
            cond_prev_reg <= cond_now;
            if (ev_read || ev_clear || reset_cmd) begin
                event_reg <= rise_set;
            end else begin
                event_reg <= event_reg | rise_set;
            end
        end
    end

    // Mask and filter writes from executed commands
    always_ff @(posedge clk) begin
        if (!resetn || reset_cmd) begin
            call_mask_reg <= MASK_RST;
            ptr_reg       <= MASK_RST;
            oper_mask_reg <= MASK_RST;
            srv_mask_reg  <= SRE_RST;
        end else if (do_cmd) begin
            case (head.sel)
                SEL_CALL_MASK: call_mask_reg <= head.data;
                SEL_CALL_PTR:  ptr_reg       <= head.data;
                SEL_OPER_MASK: oper_mask_reg <= head.data;
                SEL_SRV_MASK:  srv_mask_reg  <= head.data[7:0];
                default:       ;
            endcase
        end
    end

    // Read answers and completion reply, all from flops
    always_ff @(posedge clk) begin
        if (!resetn) begin
            read_data            <= 16'h0000;
            read_valid           <= 1'b0;
            opc_reply            <= 1'b0;
            call_state_condition <= 16'h0000;
        end else begin
            call_state_condition <= cond_now;
            read_valid           <= ev_read;
            opc_reply            <= (state_reg == CSR_REPLY);
            if (ev_read) begin
                read_data <= event_reg;
            end
        end
    end
endmodule : csr_top
`default_nettype wire

// file: sim/csr_top_asserts.sv
// Checker: port-level relations of the status reporting block
`timescale 1ns/10ps
`default_nettype none
module csr_top_asserts (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        ind_connect,
    input wire logic        std_event_sum,
    input wire logic        read_valid,
    input wire logic        opc_reply,
    input wire logic [15:0] call_state_condition,
    input wire logic [15:0] oper_condition,
    input wire logic [7:0]  status_byte,
    input wire logic        service_request
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    property p_unused; call_state_condition[2] == 1'b0; endproperty
    a_unused: assert property (p_unused) else $error("bit 2 set");
    property p_conn; $past(resetn) |->
        call_state_condition[5] == $past(ind_connect); endproperty
    a_conn: assert property (p_conn) else $error("connect bit");
    property p_high; call_state_condition[15:6] == 10'h000; endproperty
    a_high: assert property (p_high) else $error("high bits");
    property p_sb5; status_byte[5] == std_event_sum; endproperty
    a_sb5: assert property (p_sb5) else $error("status bit 5");
    property p_srq; service_request |-> status_byte[7] | status_byte[5];
    endproperty
    a_srq: assert property (p_srq) else $error("stray request");
    property p_sb7; status_byte[7] |-> oper_condition[9]; endproperty
    a_sb7: assert property (p_sb7) else $error("status bit 7");
    property p_opc; opc_reply |=> !opc_reply; endproperty
    a_opc: assert property (p_opc) else $error("reply width");
    property p_rv; read_valid |=> !read_valid; endproperty
    a_rv: assert property (p_rv) else $error("read width");
    c_opc: cover property (opc_reply);
    c_rv: cover property (read_valid);
    c_srq: cover property (service_request);
endmodule : csr_top_asserts
bind csr_top csr_top_asserts u_chk (.clk(clk), .resetn(resetn),
    .ind_connect(ind_connect), .std_event_sum(std_event_sum),
    .read_valid(read_valid), .opc_reply(opc_reply),
    .call_state_condition(call_state_condition),
    .oper_condition(oper_condition), .status_byte(status_byte),
    .service_request(service_request));
`default_nettype wire

// file: sim/csr_ctrl_model.sv
// Bus controller model: offers one command and holds it until taken
`timescale 1ns/10ps
`default_nettype none
module csr_ctrl_model (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              go,
    input  wire csr_pkg::csr_cmd_t go_cmd,
    input  wire logic              cmd_ready,
    output logic                   cmd_valid,
    output csr_pkg::csr_cmd_t      cmd
);
    import csr_pkg::*;
    // Released data is inverted so a stale value never looks valid
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmd_valid <= 1'b0;
            cmd       <= '0;
        end else if (cmd_valid && cmd_ready) begin
            cmd_valid <= 1'b0;
            cmd.data  <= ~cmd.data;
        end else if (go && !cmd_valid) begin
            cmd_valid <= 1'b1;
            cmd       <= go_cmd;
        end
    end
endmodule : csr_ctrl_model
`default_nettype wire

// file: sim/call_status_reporting_tb.sv
// Testbench: call-state status reporting block
`timescale 1ns/10ps
`default_nettype none
module call_status_reporting_tb;
    import csr_pkg::*;
    localparam int RST_N = 8;
    logic clk, resetn, std_ev, go, cmd_valid, cmd_ready, read_valid;
    logic opc_reply, srq;
    logic [4:0]  ind;
    logic [7:0]  sb;
    logic [15:0] read_data, csc, oper, rd;
    logic [31:0] lf;
    csr_cmd_t    go_cmd, cmd;
    int          err_total, cmp_count, cyc, n;
    csr_top #(.RESET_CYC(RST_N)) dut (.clk(clk), .resetn(resetn),
        .ind_connect(ind[4]), .ind_access(ind[3]), .ind_page(ind[2]),
        .ind_register(ind[1]), .ind_active(ind[0]), .std_event_sum(std_ev),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .read_data(read_data), .read_valid(read_valid),
        .opc_reply(opc_reply), .call_state_condition(csc),
        .oper_condition(oper), .status_byte(sb), .service_request(srq));
    csr_ctrl_model u_ctl (.clk(clk), .resetn(resetn), .go(go),
        .go_cmd(go_cmd), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
        .cmd(cmd));
    function automatic logic [15:0] cond_exp(logic [4:0] i);
        return {10'h000, i[4:2], 1'b0, i[1:0]};
    endfunction : cond_exp
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    // Offer one command, return at the edge that takes it
    task automatic send(logic [2:0] s, logic [15:0] d);
        @(posedge clk) go <= 1'b1;
        go_cmd <= '{s, d};
        @(posedge clk) go <= 1'b0;
        do @(negedge clk); while (!(cmd_valid && cmd_ready));
        @(posedge clk);
    endtask : send
    // Wait a bounded time for the read or reply pulse
    task automatic wait_pulse(logic opc);
        n = 0;
        do begin @(negedge clk); n++; end
        while ((opc ? opc_reply : read_valid) !== 1'b1 && n < 100);
        rd = read_data;
    endtask : wait_pulse
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin err_total++; report_and_stop; end
    end
    initial begin
        {resetn, std_ev, go, ind, cyc, err_total, cmp_count} = '0;
        go_cmd = '0;
        lf = 32'ha403;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk) check({6'h00, cmd_ready, sb, srq}, 16'h0200);
        for (int k = 0; k < 12; k++) begin
            lf = lfsr(lf);
            @(posedge clk) ind <= lf[4:0];
            @(posedge clk);
            @(negedge clk) check(csc, cond_exp(ind));
        end
        $display("condition map done");
        @(posedge clk) ind <= 5'h00;
        send(SEL_CALL_PTR, 16'h0020);
        send(SEL_CALL_MASK, 16'h003f);
        send(SEL_OPER_MASK, 16'h0200);
        send(SEL_SRV_MASK, 16'h00a0);
        @(posedge clk) ind <= 5'h08;
        repeat (4) @(posedge clk);
        @(negedge clk) check(oper, 16'h0000);
        @(posedge clk) ind <= 5'h10;
        repeat (4) @(posedge clk) ind <= 5'h00;
        @(negedge clk) check(oper, 16'h0200);
        check({sb, 7'h00, srq}, 16'h8001);
        send(SEL_READ_EVENT, 16'h0000);
        wait_pulse(1'b0);
        check(rd, 16'h0020);
        check({sb, 7'h00, srq}, 16'h0000);
        @(posedge clk) std_ev <= 1'b1;
        @(negedge clk) check({sb, 7'h00, srq}, 16'h2001);
        // Clear-status must drop a held event even with masks still set
        @(posedge clk) ind <= 5'h10;
        @(posedge clk) ind <= 5'h00;
        @(negedge clk) check(oper, 16'h0200);
        send(SEL_CLEAR, 16'h0000);
        repeat (2) @(posedge clk);
        @(negedge clk) check(oper, 16'h0000);
        $display("event path done");
        send(SEL_LONG_RESET, 16'h0000);
        send(SEL_OPC_QUERY, 16'h0000);
        wait_pulse(1'b1);
        check({15'h0000, n >= RST_N - 3 && n < 100}, 16'h0001);
        check({15'h0000, srq}, 16'h0000);
        $display("ordering done");
        report_and_stop;
    end
endmodule : call_status_reporting_tb
`default_nettype wire
